// ---- halt_standby_controller.v ----
// Standby controller: holds the CPU in one of four halt modes until wake.
// Assumes single-word AHB-Lite transfers and synchronous interrupt inputs.
`timescale 1ns/100ps
`default_nettype none
`include "standby_defines.vh"
module halt_standby_controller #(
    parameter NPERIPH = 8,   // Number of peripheral clock gates.
    parameter NPORT = 8      // Port group width.
) (
    input wire MCLK_I,
    input wire RSTN_I,
    input wire CE_I,                      // Clock enable: freezes all state except the reset synchroniser when low.
    // AHB-Lite slave.
    input wire HSEL_I,
    input wire [11:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    output wire [31:0] HRDATA_O,
    output wire HREADYOUT_O,
    output wire HRESP_O,
    // CPU and interrupt controller side.
    input wire HALT_EXEC_I,               // Pulse: halt instruction executed.
    input wire HALT_INSN_BUSY_I,          // High during the halt instruction.
    input wire [2:0] INT_LEVEL_I,         // Highest pending maskable level.
    input wire INT_PEND_I,                // A maskable source is pending.
    input wire [2:0] INT_MASK_I,          // CPU mask level.
    input wire NMI_I,
    input wire [4:0] EXT_WAKE_I,          // External wake lines 0 to 4.
    input wire KEY_WAKE_I,
    input wire RTC_INT_I,
    input wire WDT_INT_I,
    input wire ADC_INT_I,
    input wire HALT_AT_PORT_I,            // CPU stopped at the analog port address.
    output wire CPU_STALL_O,
    output wire INT_SERVICE_O,            // Pulse: service the wake interrupt.
    // Clock generator side.
    input wire CLKDIV_I,                  // Divided clock output (system clock / 2).
    output reg CPU_CLK_EN_O,
    output reg [NPERIPH-1:0] PERIPH_CLK_EN_O,
    output reg SYS_CLK_EN_O,
    output reg OSC_EN_O,
    output reg RTC_CLK_EN_O,
    output reg SLOW_CLK_SEL_O,
    output reg HIGH_OSC_EN_O,
    output reg LOW_OSC_EN_O,
    // Pins.
    output reg CLK_PIN_O,
    output reg CLK_PIN_OE_O,
    input wire [NPORT-1:0] PORT_DIR_OUT_I,    // Port pins in output mode.
    input wire [NPORT-1:0] FUNC_OUT_SEL_I,    // Pin used as an output function.
    input wire [NPORT-1:0] FUNC_OUT_DATA_I,
    input wire [NPORT-1:0] PORT_REG_I,        // Port register value.
    output reg [NPORT-1:0] PORT_OE_ALLOW_O,   // Output drive permitted.
    output reg STROBE_OE_ALLOW_O,             // Strobe drive permitted.
    output reg [NPORT-1:0] PULL_UP_O,
    output reg [NPORT-1:0] PULL_DOWN_O,
    output reg GATED_INPUT_EN_O,              // Input gate of gated pull-up pins.
    output reg ANALOG_INPUT_EN_O
);
    // ----------------------------------------
    // States (one-hot)
    // ----------------------------------------
    localparam ST_RUN = 4'h1;   // Executing.
    localparam ST_HALT = 4'h2;  // Halted, waiting for wake.
    localparam ST_WARM = 4'h4;  // Oscillator warming after stop.
    localparam ST_REL = 4'h8;   // Synchronous release cycle.

    reg rs1_r, rst_n; // Reset release synchroniser.
    reg [3:0] state_r, state_nxt;
    reg [1:0] mode_r;           // Mode latched at halt entry.
    reg [8:0] ctrl_r;           // Control register.
    reg [NPERIPH-1:0] periph_r; // Peripherals kept clocked in idle.
    reg wake_seen_r;            // Wake sample in clock idle.
    reg clkdiv_d_r;             // Previous divided clock level.
    reg [4:0] wake_src_r;       // Last wake cause for software.
    reg svc_r;
    reg [3:0] insn_cnt_r;       // Counts halt instruction states.
    wire warm_done;
    reg warm_start;

    // Two-flop reset release.
    always @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    // ----------------------------------------
    // Wake qualification
    // ----------------------------------------
    // Enabled when level is at or above the mask.
    wire lvl_ok = INT_PEND_I && (INT_LEVEL_I >= INT_MASK_I); // RULE2
    wire ext_any = |EXT_WAKE_I;
    wire clkdiv_fall = clkdiv_d_r && !CLKDIV_I; // RULE4
    reg wake_now;

    // Wake sources allowed for each mode.
    always @* begin
        case (mode_r) // RULE1
            `MODE_RUN: wake_now = clkdiv_fall && (NMI_I || ext_any || KEY_WAKE_I || RTC_INT_I
                                   || WDT_INT_I || ADC_INT_I || lvl_ok); // RULE3 RULE4
            `MODE_PERIPH_IDLE: wake_now = clkdiv_fall && (NMI_I || ext_any || KEY_WAKE_I
                                   || RTC_INT_I || lvl_ok); // RULE6
            `MODE_CLK_IDLE: wake_now = wake_seen_r; // RULE9
            default: wake_now = NMI_I || ext_any; // RULE13
        endcase
    end

    // Early wake during the halt instruction skips the halt; mode_r still latches the new mode from the control register.
    wire early_wake = HALT_INSN_BUSY_I && (insn_cnt_r < `HALT_INSN_STATES)
                      && (NMI_I || ext_any); // RULE17

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        warm_start = 1'b0;
        case (state_r)
            ST_RUN: begin
                if (HALT_EXEC_I && !early_wake) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_now) begin
                    if (mode_r == `MODE_STOP) begin
                        state_nxt = ST_WARM;
                        warm_start = 1'b1; // RULE13
                    end else begin
                        state_nxt = ST_REL; // RULE9
                    end
                end
            end
            ST_WARM: begin
                if (warm_done) begin
                    state_nxt = ST_REL; // RULE22
                end
            end
            ST_REL: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // State, mode latch, wake sampling and cause capture.
    always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RUN;
            mode_r <= `MODE_RUN;
            wake_seen_r <= 1'b0;
            clkdiv_d_r <= 1'b0;
            wake_src_r <= 5'h00;
            svc_r <= 1'b0;
            insn_cnt_r <= 4'h0;
        end else if (CE_I) begin
            state_r <= state_nxt;
            clkdiv_d_r <= CLKDIV_I;
            svc_r <= (state_r == ST_REL) && (|wake_src_r || WDT_INT_I || ADC_INT_I); // RULE2
            insn_cnt_r <= HALT_INSN_BUSY_I ? insn_cnt_r + 4'h1 : 4'h0;
            if (state_r == ST_RUN && HALT_EXEC_I) begin
                mode_r <= ctrl_r[`CTRL_MODE_LO+1:`CTRL_MODE_LO]; // RULE1
            end
            // Level-catching sample, no edge phase.
            if (state_r == ST_HALT && mode_r == `MODE_CLK_IDLE
                && (NMI_I || ext_any || KEY_WAKE_I || RTC_INT_I)) begin
                wake_seen_r <= 1'b1; // RULE10
            end else if (state_r != ST_HALT) begin
                wake_seen_r <= 1'b0;
            end
            if (state_r == ST_HALT && wake_now) begin
                wake_src_r <= {RTC_INT_I, KEY_WAKE_I, ext_any, NMI_I, lvl_ok};
            end
        end
    end

    warmup_counter #(
        .W(`WARM_W)
    ) u_warm (
        .clk_i(MCLK_I),
        .rst_n_i(rst_n),
        .ce_i(CE_I),
        .start_i(warm_start),
        .long_i(ctrl_r[`CTRL_WARM]),
        .quick_i(ctrl_r[`CTRL_QUICK]),
        .done_o(warm_done)
    );

    assign CPU_STALL_O = !state_r[0] || (state_r == ST_RUN && HALT_EXEC_I && !early_wake); // RULE22
    assign INT_SERVICE_O = svc_r;

    // ----------------------------------------
    // Clock, pin and pull control outputs
    // ----------------------------------------
    wire halted = (state_r == ST_HALT);
    wire in_stop = (halted || state_r == ST_WARM) && (mode_r == `MODE_STOP);
    wire drv = ctrl_r[`CTRL_DRIVE];
    integer i;

    always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            CPU_CLK_EN_O <= 1'b1;
            PERIPH_CLK_EN_O <= {NPERIPH{1'b1}};
            SYS_CLK_EN_O <= 1'b1;
            OSC_EN_O <= 1'b1;
            RTC_CLK_EN_O <= 1'b1;
            SLOW_CLK_SEL_O <= 1'b0;
            HIGH_OSC_EN_O <= 1'b1;
            LOW_OSC_EN_O <= 1'b0;
            CLK_PIN_O <= 1'b1;
            CLK_PIN_OE_O <= 1'b0;
            PORT_OE_ALLOW_O <= {NPORT{1'b1}};
            STROBE_OE_ALLOW_O <= 1'b1;
            PULL_UP_O <= {NPORT{1'b0}};
            PULL_DOWN_O <= {NPORT{1'b0}};
            GATED_INPUT_EN_O <= 1'b1;
            ANALOG_INPUT_EN_O <= 1'b1;
        end else if (CE_I) begin
            CPU_CLK_EN_O <= !(halted || state_r == ST_WARM); // RULE3
            // Peripheral idle gates off unselected peripherals.
            if (halted && mode_r == `MODE_PERIPH_IDLE) begin
                PERIPH_CLK_EN_O <= periph_r; // RULE5
            end else if ((halted && mode_r != `MODE_RUN) || in_stop) begin
                PERIPH_CLK_EN_O <= {NPERIPH{1'b0}};
            end else begin
                PERIPH_CLK_EN_O <= {NPERIPH{1'b1}};
            end
            SYS_CLK_EN_O <= !((halted && mode_r == `MODE_CLK_IDLE) || in_stop); // RULE8 RULE13
            OSC_EN_O <= !(halted && mode_r == `MODE_STOP); // RULE12
            RTC_CLK_EN_O <= !in_stop; // RULE8
            if (state_r == ST_REL && mode_r == `MODE_STOP) begin
                SLOW_CLK_SEL_O <= ctrl_r[`CTRL_RELEASE_CLOCK_SELECT]; // RULE16
                HIGH_OSC_EN_O <= ctrl_r[`CTRL_RELEASE_HIGH_OSC_ENABLE]; // RULE16
                LOW_OSC_EN_O <= ctrl_r[`CTRL_RELEASE_LOW_OSC_ENABLE]; // RULE16
            end
            // Clock pin: high in clock idle, floats in stop with drive 0.
            CLK_PIN_OE_O <= ctrl_r[`CTRL_CLKEN] && !(in_stop && !drv);
            CLK_PIN_O <= (halted && mode_r == `MODE_CLK_IDLE) || in_stop ? 1'b1 : CLKDIV_I; // RULE8
            STROBE_OE_ALLOW_O <= !(in_stop && !drv); // RULE18
            GATED_INPUT_EN_O <= !(in_stop && !drv); // RULE19
            ANALOG_INPUT_EN_O <= !(state_r != ST_RUN) || HALT_AT_PORT_I; // RULE20
            for (i = 0; i < NPORT; i = i + 1) begin
                PORT_OE_ALLOW_O[i] <= !(in_stop && !drv && PORT_DIR_OUT_I[i]); // RULE18
                if (FUNC_OUT_SEL_I[i]) begin
                    PULL_UP_O[i] <= FUNC_OUT_DATA_I[i]; // RULE21
                    PULL_DOWN_O[i] <= !FUNC_OUT_DATA_I[i]; // RULE21
                end else begin
                    PULL_UP_O[i] <= PORT_REG_I[i]; // RULE21
                    PULL_DOWN_O[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    reg dp_wr_r;        // Write data phase pending.
    reg [11:0] dp_addr_r;
    reg [31:0] rdata_r;

    // Single-cycle data phase, zero wait states, always OKAY.
    always @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 12'h000;
            rdata_r <= 32'h00000000;
            ctrl_r <= `CTRL_RESET;
            periph_r <= {NPERIPH{1'b0}};
        end else if (CE_I) begin
            if (dp_wr_r) begin
                if (dp_addr_r == `REG_CTRL) begin
                    ctrl_r <= HWDATA_I[8:0];
                end else if (dp_addr_r == `REG_PERIPH) begin
                    periph_r <= HWDATA_I[NPERIPH-1:0];
                end
            end
            if (HREADY_I && HSEL_I && HTRANS_I == `HTRANS_NONSEQ) begin
                dp_wr_r <= HWRITE_I;
                dp_addr_r <= HADDR_I;
                if (HADDR_I == `REG_CTRL) begin
                    rdata_r <= {23'h000000, ctrl_r};
                end else if (HADDR_I == `REG_STATUS) begin
                    rdata_r <= {26'h0000000, state_r, mode_r};
                end else if (HADDR_I == `REG_PERIPH) begin
                    rdata_r <= {{(32-NPERIPH){1'b0}}, periph_r};
                end else if (HADDR_I == `REG_WAKE) begin
                    rdata_r <= {27'h0000000, wake_src_r};
                end else begin
                    rdata_r <= 32'h00000000;
                end
            end else begin
                dp_wr_r <= 1'b0;
            end
        end
    end

    assign HRDATA_O = rdata_r;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
endmodule // halt_standby_controller
`default_nettype wire

// ---- standby_defines.vh ----
// Constants of the standby controller: mode codes, warm-up, register map.
// Included by bare name; definitions only.
//
// Contract
// RULE1: Mode code 00 run,11 periph,10 clk,01 stop.
// RULE2: Enabled wake interrupts release; external lines always.
// RULE3: Run halt keeps clocks, stops only CPU.
// RULE4: Run halt accepts interrupts on clock-out fall.
// RULE5: Peripheral idle clocks only selected peripherals.
// RULE6: Peripheral idle wakes except watchdog, conversion-done.
// RULE7: Software disables watchdog before peripheral idle.
// RULE8: Clock idle keeps oscillator, RTC; clock-out high.
// RULE9: Clock idle samples async, releases synchronously.
// RULE10: Clock idle wakes: NMI, external, key, RTC.
// RULE11: Software stops prescaler before idle halt.
// RULE12: Full stop halts oscillator; pins per drive.
// RULE13: Stop wakes NMI/external; clock after warm-up.
// RULE14: Warm-up 2^14 or 2^16 periods by select.
// RULE15: Quick-start bit shortens the warm-up.
// RULE16: Release clock select picks normal or slow.
// RULE17: Wake during halt instruction keeps mode.
// RULE18: Drive 0 floats outputs, strobes; 1 drives.
// RULE19: Drive 0 gated pull-up pins disable inputs.
// RULE20: Analog port input only at stopped address.
// RULE21: Output function picks pull by its data.
// RULE22: Stall held until wake and warm-up done.
`ifndef STANDBY_DEFINES_VH
`define STANDBY_DEFINES_VH

// ----------------------------------------
// Halt mode codes
// ----------------------------------------
`define MODE_RUN 2'h0
`define MODE_STOP 2'h1
`define MODE_CLK_IDLE 2'h2
`define MODE_PERIPH_IDLE 2'h3

// ----------------------------------------
// Warm-up and timing
// ----------------------------------------
`define WARM_SHORT_EXP 14
`define WARM_LONG_EXP 16
`define QUICK_WARM_CYCLES 18'h00010
`define HALT_INSN_STATES 4'h8
`define WARM_W 18

// ----------------------------------------
// AHB-Lite register map (byte addresses)
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_PERIPH 12'h008
`define REG_WAKE 12'h00C
`define HTRANS_NONSEQ 2'h2

// Control fields.
`define CTRL_MODE_LO 0
`define CTRL_DRIVE 2
`define CTRL_WARM 3
`define CTRL_QUICK 4
`define CTRL_RELEASE_CLOCK_SELECT 5
`define CTRL_RELEASE_HIGH_OSC_ENABLE 6
`define CTRL_RELEASE_LOW_OSC_ENABLE 7
`define CTRL_CLKEN 8
`define CTRL_RESET 9'h000

`endif

// ---- warmup_counter.v ----
// Oscillator warm-up counter used when leaving full stop.
// Assumes the synchronised active-low reset and shared clock enable.
`timescale 1ns/100ps
`default_nettype none
`include "standby_defines.vh"
module warmup_counter #(
    parameter W = `WARM_W
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire start_i,      // Starts the count.
    input wire long_i,       // Warm-up select bit.
    input wire quick_i,      // Quick start.
    output reg done_o        // Count expired.
);
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    reg [W-1:0] cnt_r; // Remaining periods.
    reg run_r; // Counting in progress.

    // Load on start, count down, flag done at zero.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= {W{1'b0}};
            run_r <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            if (start_i) begin
                run_r <= 1'b1;
                done_o <= 1'b0;
                if (quick_i) begin
                    cnt_r <= `QUICK_WARM_CYCLES; // RULE15
                end else if (long_i) begin
                    cnt_r <= {{(W-`WARM_LONG_EXP-1){1'b0}}, 1'b1, {`WARM_LONG_EXP{1'b0}}} - 1'b1; // RULE14
                end else begin
                    cnt_r <= {{(W-`WARM_SHORT_EXP-1){1'b0}}, 1'b1, {`WARM_SHORT_EXP{1'b0}}} - 1'b1; // RULE14
                end
            end else if (run_r) begin
                if (cnt_r == {W{1'b0}}) begin
                    run_r <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end else begin
                done_o <= 1'b0;
            end
        end
    end
endmodule // warmup_counter
`default_nettype wire

// ---- standby_props.sv ----
// Checker of the standby controller's ports.
// Bound into halt_standby_controller; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module standby_props #(
    parameter NPORT = 8
) (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic HALT_EXEC_I,
    input wire logic NMI_I,
    input wire logic [4:0] EXT_WAKE_I,
    input wire logic CPU_STALL_O,
    input wire logic INT_SERVICE_O,
    input wire logic SYS_CLK_EN_O,
    input wire logic CPU_CLK_EN_O,
    input wire logic OSC_EN_O,
    input wire logic CLK_PIN_O,
    input wire logic CLK_PIN_OE_O,
    input wire logic [NPORT-1:0] PORT_DIR_OUT_I,
    input wire logic [NPORT-1:0] PORT_OE_ALLOW_O,
    input wire logic STROBE_OE_ALLOW_O,
    input wire logic GATED_INPUT_EN_O
);
    // One clock domain.
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    // Oscillator restart opens a warm-up.
    sequence osc_back_s;
        $rose(OSC_EN_O);
    endsequence
    // Shortest warm-up is 16 cycles; 8 is a safe floor.
    sequence clk_held_s;
        !SYS_CLK_EN_O [*8];
    endsequence
    halt_stall_a: assert property (HALT_EXEC_I && !NMI_I && EXT_WAKE_I == 5'h00 |-> CPU_STALL_O)
        else $error("stall missing at halt entry");
    stop_clocks_a: assert property (!OSC_EN_O |-> !SYS_CLK_EN_O && CPU_STALL_O)
        else $error("clock or CPU running with oscillator off");
    warm_gap_a: assert property (osc_back_s |-> clk_held_s)
        else $error("system clock back before warm-up");
    release_osc_a: assert property ($fell(CPU_STALL_O) |-> OSC_EN_O)
        else $error("stall released with oscillator off");
    svc_pulse_a: assert property (INT_SERVICE_O |=> !INT_SERVICE_O)
        else $error("service pulse too long");
    svc_run_a: assert property (INT_SERVICE_O |-> !CPU_STALL_O)
        else $error("service pulse while stalled");
    idle_pin_a: assert property (CPU_STALL_O && OSC_EN_O && !SYS_CLK_EN_O && CLK_PIN_OE_O |-> CLK_PIN_O)
        else $error("clock pin not high in clock idle");
    drive_group_a: assert property (PORT_OE_ALLOW_O == ~($past(PORT_DIR_OUT_I) & {NPORT{!STROBE_OE_ALLOW_O}}))
        else $error("port and strobe drive disagree");
    gate_off_a: assert property (!STROBE_OE_ALLOW_O |-> !GATED_INPUT_EN_O)
        else $error("input gate open in float");
    cpu_off_a: assert property (CPU_STALL_O [*3] |-> !CPU_CLK_EN_O)
        else $error("CPU clock on during halt");
endmodule // standby_props
bind halt_standby_controller standby_props #(.NPORT(NPORT)) chk (.*);
`default_nettype wire

// ---- cpu_intc_model.sv ----
// Partner: CPU and interrupt controller that halt and wake the block.
// Bench calls its tasks; outputs change by NBA after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module cpu_intc_model (
    input wire logic MCLK_I,
    input wire logic CPU_STALL_O,
    input wire logic INT_SERVICE_O,
    output logic HALT_EXEC_I,
    output logic HALT_INSN_BUSY_I,
    output logic [2:0] INT_LEVEL_I,
    output logic INT_PEND_I,
    output logic [2:0] INT_MASK_I,
    output logic NMI_I,
    output logic [4:0] EXT_WAKE_I,
    output logic KEY_WAKE_I,
    output logic RTC_INT_I,
    output logic WDT_INT_I,
    output logic ADC_INT_I,
    output logic HALT_AT_PORT_I
);
    // Quiet at start; watchdog raised only as wake source 5.
    initial begin
        {HALT_EXEC_I, HALT_INSN_BUSY_I, INT_PEND_I, NMI_I, KEY_WAKE_I, RTC_INT_I} = 6'h00;
        {WDT_INT_I, ADC_INT_I, HALT_AT_PORT_I, EXT_WAKE_I} = 8'h00;
        INT_LEVEL_I = 3'h0;
        INT_MASK_I = 3'h7;
    end
    // Halt: one-cycle pulse, busy 8 states; early raises NMI within.
    task automatic halt(input logic early, input logic at_port);
        @(posedge MCLK_I);
        HALT_EXEC_I <= 1'b1;
        HALT_INSN_BUSY_I <= 1'b1;
        HALT_AT_PORT_I <= at_port;
        NMI_I <= early;
        @(posedge MCLK_I);
        HALT_EXEC_I <= 1'b0;
        repeat (7) @(posedge MCLK_I);
        HALT_INSN_BUSY_I <= 1'b0;
        NMI_I <= 1'b0;
    endtask
    // Hold one source until the stall drops or lim cycles pass, then 5 more cycles.
    task automatic wake(input int s, input logic [4:0] ext, input int lim,
                        output logic woke, output logic srv, output int n);
        @(posedge MCLK_I);
        INT_LEVEL_I <= (s == 7) ? 3'h2 : 3'h5;
        INT_MASK_I <= (s == 7) ? 3'h4 : 3'h3;
        INT_PEND_I <= (s == 0 || s == 7);
        NMI_I <= (s == 1);
        EXT_WAKE_I <= (s == 2) ? ext : 5'h00;
        {KEY_WAKE_I, RTC_INT_I, WDT_INT_I, ADC_INT_I} <= {s == 3, s == 4, s == 5, s == 6};
        n = 0;
        srv = 1'b0;
        do begin
            @(posedge MCLK_I);
            n++;
        end while (CPU_STALL_O === 1'b1 && n < lim);
        woke = (CPU_STALL_O === 1'b0);
        repeat (5) begin
            srv |= (INT_SERVICE_O === 1'b1);
            @(posedge MCLK_I);
        end
        {INT_PEND_I, NMI_I, KEY_WAKE_I, RTC_INT_I, WDT_INT_I, ADC_INT_I} <= 6'h00;
        EXT_WAKE_I <= 5'h00;
    endtask
endmodule // cpu_intc_model
`default_nettype wire

// ---- tb_top.sv ----
// Bench: registers, each halt mode against each wake source, warm-up.
// Assumes design, partner model and checker compile first.
`timescale 1ns/100ps
`default_nettype none
`include "standby_defines.vh"
module tb_top;
    logic MCLK_I = 1'b0;
    logic RSTN_I = 1'b0;
    logic CE_I = 1'b1; // Freeze not exercised.
    logic HSEL_I = 1'b0, HWRITE_I = 1'b0, HREADY_I, HREADYOUT_O, HRESP_O;
    logic [11:0] HADDR_I = 12'h000;
    logic [1:0] HTRANS_I = 2'h0;
    logic [2:0] HSIZE_I = 3'h2;
    logic [31:0] HWDATA_I = 32'h0, HRDATA_O;
    logic HALT_EXEC_I, HALT_INSN_BUSY_I, INT_PEND_I, NMI_I, KEY_WAKE_I, RTC_INT_I, WDT_INT_I, ADC_INT_I;
    logic HALT_AT_PORT_I, CPU_STALL_O, INT_SERVICE_O, CLKDIV_I = 1'b0;
    logic [2:0] INT_LEVEL_I, INT_MASK_I;
    logic [4:0] EXT_WAKE_I;
    logic CPU_CLK_EN_O, SYS_CLK_EN_O, OSC_EN_O, RTC_CLK_EN_O, SLOW_CLK_SEL_O, HIGH_OSC_EN_O, LOW_OSC_EN_O;
    logic CLK_PIN_O, CLK_PIN_OE_O, STROBE_OE_ALLOW_O, GATED_INPUT_EN_O, ANALOG_INPUT_EN_O;
    logic [7:0] PERIPH_CLK_EN_O, PORT_OE_ALLOW_O, PULL_UP_O, PULL_DOWN_O;
    logic [7:0] PORT_DIR_OUT_I = 8'h00, FUNC_OUT_SEL_I = 8'h00, FUNC_OUT_DATA_I = 8'h00, PORT_REG_I = 8'h00;
    logic [31:0] seed = 32'h01B06167; // Fixed seed.
    logic [31:0] d;
    int n_fail = 0;
    int comparisons = 0;

    halt_standby_controller DUT (.*);
    cpu_intc_model cpu (.*);
    assign HREADY_I = HREADYOUT_O; // Single slave.
    always #50 MCLK_I = ~MCLK_I;
    // Divided clock: half the system clock.
    always @(posedge MCLK_I) CLKDIV_I <= ~CLKDIV_I;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function logic [31:0] nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Sources: maskable, NMI, ext, key, RTC, watchdog, conversion, masked.
    function automatic logic exp_wake(input logic [1:0] m, input int s);
        logic [7:0] t;
        case (m)
            `MODE_RUN: t = 8'h7F;
            `MODE_PERIPH_IDLE: t = 8'h1F;
            `MODE_CLK_IDLE: t = 8'h1E;
            default: t = 8'h06;
        endcase
        return t[s];
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One AHB-Lite word; waits on ready in both phases.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge MCLK_I);
        {HSEL_I, HWRITE_I, HADDR_I, HTRANS_I} <= {1'b1, w, a, 2'h2};
        do @(posedge MCLK_I); while (HREADY_I !== 1'b1);
        {HSEL_I, HTRANS_I, HWDATA_I} <= {1'b0, 2'h0, wd};
        do @(posedge MCLK_I); while (HREADY_I !== 1'b1);
        rd = HRDATA_O;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // One halt in mode m, woken by source s
    // ----------------------------------------
    task automatic run_case(input logic [1:0] m, input int s, input logic w, input logic q);
        logic [31:0] c, r;
        logic [7:0] pe, up, dn;
        logic woke, srv;
        int n, e;
        c = nxt();
        r = nxt();
        pe = r[7:0];
        c[4:0] = {q, w, c[2], m};
        c[8] = 1'b1;
        {PORT_DIR_OUT_I, FUNC_OUT_SEL_I, FUNC_OUT_DATA_I, PORT_REG_I} <= nxt();
        xfer(1'b1, `REG_CTRL, {23'h0, c[8:0]}, d);
        xfer(1'b1, `REG_PERIPH, {24'h0, pe}, d);
        xfer(1'b0, `REG_CTRL, 32'h0, d);
        chk("ctrl", {23'h0, c[8:0]}, d);
        xfer(1'b0, `REG_PERIPH, 32'h0, d);
        chk("periph select", {24'h0, pe}, d);
        cpu.halt(1'b0, r[9]);
        xfer(1'b0, `REG_STATUS, 32'h0, d);
        chk("status mode", m, d[1:0]);
        chk("analog gate", r[9], ANALOG_INPUT_EN_O);
        up = (FUNC_OUT_SEL_I & FUNC_OUT_DATA_I) | (~FUNC_OUT_SEL_I & PORT_REG_I);
        dn = FUNC_OUT_SEL_I & ~FUNC_OUT_DATA_I;
        case (m)
            `MODE_RUN: chk("run clocks", {2'h2, 8'hFF}, {SYS_CLK_EN_O, CPU_CLK_EN_O, PERIPH_CLK_EN_O});
            `MODE_PERIPH_IDLE: chk("periph clocks", {1'b0, pe}, {CPU_CLK_EN_O, PERIPH_CLK_EN_O});
            `MODE_CLK_IDLE: chk("clk idle", 5'h1B, {OSC_EN_O, RTC_CLK_EN_O, SYS_CLK_EN_O, CLK_PIN_O, CLK_PIN_OE_O});
            default: begin
                chk("stop pins", {1'b0, {2{c[2]}}, ~(PORT_DIR_OUT_I & {8{~c[2]}})},
                    {OSC_EN_O, STROBE_OE_ALLOW_O, GATED_INPUT_EN_O, PORT_OE_ALLOW_O});
                chk("stop pulls", {up, dn}, {PULL_UP_O, PULL_DOWN_O});
            end
        endcase
        cpu.wake(s, 5'h01 << (r[14:12] % 5), (m == `MODE_STOP && !q) ? 70000 : 40, woke, srv, n);
        chk("wake", exp_wake(m, s), woke);
        if (!woke) begin
            cpu.wake(1, 5'h00, 40, woke, srv, n);
            chk("nmi wake", 1'b1, woke);
        end
        chk("service", 1'b1, srv);
        if (m == `MODE_STOP) begin
            e = q ? 16 : (w ? 65536 : 16384);
            comparisons++;
            if (n < e || n > e + 10) begin
                n_fail++;
                $display("FAIL warm-up expected %0d seen %0d", e, n);
            end
            chk("release clocks", c[7:5], {LOW_OSC_EN_O, HIGH_OSC_EN_O, SLOW_CLK_SEL_O});
        end
        $display("case mode %0d source %0d done", m, s);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge MCLK_I);
        RSTN_I <= 1'b1;
        repeat (3) @(posedge MCLK_I);
        xfer(1'b0, `REG_CTRL, 32'h0, d);
        chk("ctrl reset", 32'h0, d);
        xfer(1'b1, 12'h010, nxt(), d);
        xfer(1'b0, 12'h010, 32'h0, d);
        chk("unmapped", 32'h0, d);
        $display("register test done");
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 8; s++) begin
                run_case(m[1:0], s, 1'b0, 1'b1);
            end
        end
        run_case(`MODE_STOP, 2, 1'b0, 1'b0);
        run_case(`MODE_STOP, 1, 1'b1, 1'b0);
        xfer(1'b1, `REG_CTRL, {23'h0, 9'h011}, d);
        cpu.halt(1'b1, 1'b0);
        chk("early wake", 2'h1, {CPU_STALL_O, OSC_EN_O});
        $display("early wake test done");
        wrap_up();
    end
    // Watchdog: long warm-ups use about 82000 cycles.
    initial begin
        repeat (98000) @(posedge MCLK_I);
        n_fail++;
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
